// *** hdl/gfs_map.svh ***
`ifndef GFS_MAP_SVH
`define GFS_MAP_SVH

// Register offset and reset image of the global fault register.
`define GFS_ADDR_W             6
`define GFS_OFFSET             6'h04
`define GFS_RESET_VALUE        16'h0147
`define GFS_DATA_W             16
`define GFS_FLAG_W             9

// Field positions inside the global fault register.
`define GFS_BIT_GLOBAL         8
`define GFS_BIT_FALLBACK       7
`define GFS_BIT_POR            6
`define GFS_BIT_LOWPOWER       5
`define GFS_BIT_SPI_ERR        4
`define GFS_BIT_TIMEOUT        3
`define GFS_BIT_LOGIC_LOW      2
`define GFS_BIT_BATT_WARN      1
`define GFS_BIT_BATT_LOCK      0

// Synchroniser depth for pin inputs.
`define GFS_SYNC_STAGES        2
`define GFS_PIN_W              4

`endif

// *** hdl/gfs_pkg.sv ***
package gfs_pkg;

  typedef logic [8:0] gfs_flags_t;

  typedef enum logic
  {
    GFS_RD_IDLE,
    GFS_RD_PENDING
  } gfs_rd_state_t;

endpackage : gfs_pkg

// *** hdl/gfs_sync.sv ***
`include "gfs_map.svh"

// Two-stage synchroniser for asynchronous pin levels.
module gfs_sync #(
  parameter int WIDTH = `GFS_PIN_W
) (
  input  wire logic             sys_clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      logic meta_q;
      logic sync_q;
      always_ff @(posedge sys_clk)
      begin
        if (!reset_n)
        begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
        end
        else
        begin
          meta_q <= async_in[i];
          sync_q <= meta_q;
        end
      end
      assign sync_out[i] = sync_q;
    end
  endgenerate

endmodule : gfs_sync

// *** hdl/gfs_global_fault.sv ***
`include "gfs_map.svh"

// Functional notes
// - Bit 8 is set whenever any of the global event bits 7 to 0 is set.
// - With fault hold disable at 0, bit 8 stays set until a read completes and no event remains.
// - With fault hold disable at 1, bit 8 falls as soon as no event remains, without a read.
// - A rising fallback request pin sets bit 7 and enters the fallback state.
// - Writing 1 to bit 7 clears it and leaves the fallback state, done only while the pin is low.
// - Bit 6 is 1 after every power-on reset and is cleared by a read.
// - Bit 5 is set on entry to either low-power mode and cleared by a read only when none is active.
// - A refused manual low-power request still sets bit 5, which a read then clears.
// - Bit 4 latches any frame, clock count or CRC error and clears on a read once the error is gone.
// - With the timeout enable at 1, bit 3 latches a host timeout and clears on a read once gone.
// - Bit 2 resets to 1, is set while the logic supply is low and clears on a read after recovery.
// - Bit 1 resets to 1, is set while the battery is below warning, disables diagnostics then.
// - Bit 0 resets to 1, is set while the battery is locked out and clears on a read after recovery.
// - The register sits at offset 4h and reads 0147h after reset.
module gfs_global_fault #(
  parameter int ADDR_W = `GFS_ADDR_W
) (
  input  wire logic              sys_clk,
  input  wire logic              reset_n,
  input  wire logic              fallback_request_pin,
  input  wire logic              logic_supply_low_pin,
  input  wire logic              battery_warn_pin,
  input  wire logic              battery_lockout_pin,
  input  wire logic              fault_hold_disable,
  input  wire logic              host_timeout_enable,
  input  wire logic              host_timeout_expired,
  input  wire logic              spi_error_cond,
  input  wire logic              self_lowpower_mode,
  input  wire logic              host_lowpower_mode,
  input  wire logic              lowpower_entry_refused,
  input  wire logic              reg_rd_strobe,
  input  wire logic              reg_wr_strobe,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [15:0]       reg_wdata,
  input  wire logic              frame_done_ok,
  input  wire logic              frame_done_err,
  output logic      [15:0]       rd_data_q,
  output logic                   rd_valid_q,
  output logic                   fallback_state_q,
  output logic                   diag_disable_q,
  output logic                   global_event_flag_q
);

  logic [`GFS_PIN_W-1:0] pin_s;
  logic                  fallback_pin_s;
  logic                  logic_low_s;
  logic                  batt_warn_s;
  logic                  batt_lock_s;
  logic                  fallback_prev_q;
  logic                  lowpower_prev_q;
  logic                  lowpower_active;
  logic                  fallback_rise;
  logic                  reg_hit;
  logic                  clear_go;
  logic                  fallback_w1c;
  logic                  global_d;
  gfs_pkg::gfs_flags_t   flags_q;
  gfs_pkg::gfs_flags_t   flags_d;
  gfs_pkg::gfs_flags_t   snap_q;
  gfs_pkg::gfs_flags_t   cond_v;
  gfs_pkg::gfs_flags_t   set_v;
  gfs_pkg::gfs_rd_state_t rd_state_q;

  gfs_sync #(
    .WIDTH (`GFS_PIN_W)
  ) u_sync (
    .sys_clk  (sys_clk),
    .reset_n  (reset_n),
    .async_in ({fallback_request_pin, logic_supply_low_pin, battery_warn_pin,
                battery_lockout_pin}),
    .sync_out (pin_s)
  );

  assign fallback_pin_s  = pin_s[3];
  assign logic_low_s     = pin_s[2];
  assign batt_warn_s     = pin_s[1];
  assign batt_lock_s     = pin_s[0];
  assign lowpower_active = self_lowpower_mode | host_lowpower_mode;
  assign fallback_rise   = fallback_pin_s & ~fallback_prev_q;
  assign reg_hit         = (reg_addr == `GFS_OFFSET);

  // Edge history for the fallback pin and low-power mode entry.
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      fallback_prev_q <= 1'b0;
      lowpower_prev_q <= 1'b0;
    end
    else
    begin
      fallback_prev_q <= fallback_pin_s;
      lowpower_prev_q <= lowpower_active;
    end
  end

  // A read of this register is pending until its frame ends; an error frame drops it.
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      rd_state_q <= gfs_pkg::GFS_RD_IDLE;
    end
    else
    begin
      unique case (rd_state_q)
        gfs_pkg::GFS_RD_IDLE:
        begin
          if (reg_rd_strobe && reg_hit)
          begin
            rd_state_q <= gfs_pkg::GFS_RD_PENDING;
          end
        end
        gfs_pkg::GFS_RD_PENDING:
        begin
          if (frame_done_ok || frame_done_err)
          begin
            rd_state_q <= gfs_pkg::GFS_RD_IDLE;
          end
        end
      endcase
    end
  end

  assign clear_go = frame_done_ok && (rd_state_q == gfs_pkg::GFS_RD_PENDING);

  // Read data is the flag image before any clear; only bits read as 1 are cleared later.
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      rd_data_q  <= 16'h0000;
      rd_valid_q <= 1'b0;
      snap_q     <= '0;
    end
    else
    begin
      rd_valid_q <= reg_rd_strobe;
      if (reg_rd_strobe)
      begin
        rd_data_q <= reg_hit ? {7'h00, flags_q} : 16'h0000;
        if (reg_hit)
        begin
          snap_q <= flags_q;
        end
      end
    end
  end

  // Condition still present, and set request, for the read-to-clear bits.
  always_comb
  begin
    cond_v                      = '0;
    cond_v[`GFS_BIT_LOWPOWER]   = lowpower_active;
    cond_v[`GFS_BIT_SPI_ERR]    = spi_error_cond;
    cond_v[`GFS_BIT_TIMEOUT]    = host_timeout_enable & host_timeout_expired;
    cond_v[`GFS_BIT_LOGIC_LOW]  = logic_low_s;
    cond_v[`GFS_BIT_BATT_WARN]  = batt_warn_s;
    cond_v[`GFS_BIT_BATT_LOCK]  = batt_lock_s;
    set_v                       = cond_v;
    set_v[`GFS_BIT_LOWPOWER]    = (lowpower_active & ~lowpower_prev_q)
                                  | lowpower_entry_refused;
  end

  // A new event wins over a clear in the same cycle.
  genvar b;
  generate
    for (b = 0; b < `GFS_BIT_FALLBACK; b++)
    begin : g_rc
      assign flags_d[b] = set_v[b]
                          | (flags_q[b] & ~(clear_go & snap_q[b] & ~cond_v[b]));
    end
  endgenerate

  assign fallback_w1c = reg_wr_strobe && reg_hit && reg_wdata[`GFS_BIT_FALLBACK]
                        && !fallback_pin_s;
  assign flags_d[`GFS_BIT_FALLBACK] = fallback_rise
                                      | (flags_q[`GFS_BIT_FALLBACK] & ~fallback_w1c);

  // The summary is built apart so that the flag vector has only continuous drivers.
  always_comb
  begin
    if (fault_hold_disable)
    begin
      global_d = |flags_d[7:0];
    end
    else
    begin
      global_d = (|flags_d[7:0])
                 | (flags_q[`GFS_BIT_GLOBAL] & ~clear_go);
    end
  end

  assign flags_d[`GFS_BIT_GLOBAL] = global_d;

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      flags_q <= gfs_pkg::gfs_flags_t'(`GFS_RESET_VALUE);
    end
    else
    begin
      flags_q <= flags_d;
    end
  end

  // The fallback and summary outputs are registered from the next flag state, so they change in the same cycle as their bits.
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      fallback_state_q    <= 1'b0;
      diag_disable_q      <= 1'b0;
      global_event_flag_q <= 1'b1;
    end
    else
    begin
      fallback_state_q    <= flags_d[`GFS_BIT_FALLBACK];
      diag_disable_q      <= batt_warn_s;
      global_event_flag_q <= flags_d[`GFS_BIT_GLOBAL];
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  sequence seq_read_taken;
    reg_rd_strobe && reg_hit && (rd_state_q == gfs_pkg::GFS_RD_IDLE);
  endsequence

  // Only a good frame end that closes a pending read of this register counts.
  sequence seq_frame_ok;
    frame_done_ok && !frame_done_err && (rd_state_q == gfs_pkg::GFS_RD_PENDING);
  endsequence

  summary_follows_a : assert property (
    (|flags_q[7:0]) |-> flags_q[`GFS_BIT_GLOBAL])
    else $error("summary flag low while an event bit is set");

  summary_held_a : assert property (
    (flags_q[`GFS_BIT_GLOBAL] && !fault_hold_disable && !clear_go) |=> flags_q[`GFS_BIT_GLOBAL])
    else $error("latched summary flag dropped without a read");

  summary_unlatched_a : assert property (
    fault_hold_disable |=> (flags_q[`GFS_BIT_GLOBAL] == (|flags_q[7:0])))
    else $error("unlatched summary flag does not track events");

  fallback_entry_a : assert property (
    $rose(fallback_pin_s) |=> (flags_q[`GFS_BIT_FALLBACK] && fallback_state_q))
    else $error("fallback state not entered on pin rise");

  fallback_clear_a : assert property (
    (fallback_w1c && !fallback_rise) |=> (!flags_q[`GFS_BIT_FALLBACK] && !fallback_state_q))
    else $error("fallback flag not cleared by write of one");

  por_read_clear_a : assert property (
    (seq_read_taken ##[1:5] seq_frame_ok)
    |=> (!flags_q[`GFS_BIT_POR]))
    else $error("power-on flag survived a completed read");

  lowpower_kept_a : assert property (
    (flags_q[`GFS_BIT_LOWPOWER] && lowpower_active) |=> flags_q[`GFS_BIT_LOWPOWER])
    else $error("low-power flag cleared while a mode is active");

  refused_entry_a : assert property (
    lowpower_entry_refused |=> flags_q[`GFS_BIT_LOWPOWER])
    else $error("refused manual entry did not set low-power flag");

  spi_error_latch_a : assert property (
    spi_error_cond |=> flags_q[`GFS_BIT_SPI_ERR] ##0 flags_q[`GFS_BIT_GLOBAL])
    else $error("serial error not latched");

  timeout_latch_a : assert property (
    (host_timeout_enable && host_timeout_expired) |=> flags_q[`GFS_BIT_TIMEOUT])
    else $error("host timeout not latched");

  logic_low_latch_a : assert property (
    $rose(logic_supply_low_pin) |-> ##3 flags_q[`GFS_BIT_LOGIC_LOW])
    else $error("logic supply low not flagged after synchroniser delay");

  batt_warn_diag_a : assert property (
    batt_warn_s |=> (flags_q[`GFS_BIT_BATT_WARN] && diag_disable_q))
    else $error("battery warning not flagged or diagnostics still on");

  batt_lock_latch_a : assert property (
    batt_lock_s |=> flags_q[`GFS_BIT_BATT_LOCK])
    else $error("battery lockout not flagged");

  read_snapshot_a : assert property (
    seq_read_taken |=> (rd_data_q == {7'h00, $past(flags_q)}))
    else $error("read data differs from flags at the read");

  error_frame_keep_a : assert property (
    (flags_q[`GFS_BIT_POR] && !clear_go) |=> flags_q[`GFS_BIT_POR])
    else $error("power-on flag cleared without a good frame end");

  other_addr_zero_a : assert property (
    (reg_rd_strobe && !reg_hit) |=> (rd_data_q == 16'h0000))
    else $error("read of another offset returned nonzero data");

  read_valid_a : assert property (
    reg_rd_strobe |=> rd_valid_q)
    else $error("read strobe not answered by valid");

endmodule : gfs_global_fault

// *** verif/gfs_host_model.sv ***
// Host side of the register path: issues one read or write per frame and ends it.
module gfs_host_model (
  input  wire logic        sys_clk,
  input  wire logic        rd_valid_q,
  input  wire logic [15:0] rd_data_q,
  output logic             reg_rd_strobe,
  output logic             reg_wr_strobe,
  output logic [5:0]       reg_addr,
  output logic [15:0]      reg_wdata,
  output logic             frame_done_ok,
  output logic             frame_done_err
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    reg_rd_strobe  = 1'b0;
    reg_wr_strobe  = 1'b0;
    reg_addr       = 6'h00;
    reg_wdata      = 16'h0000;
    frame_done_ok  = 1'b0;
    frame_done_err = 1'b0;
  end

  // Ends a frame; a bad frame must leave every flag in place.
  task automatic end_frame(input logic bad);
    @(negedge sys_clk);
    frame_done_ok  = !bad;
    frame_done_err = bad;
    @(negedge sys_clk);
    frame_done_ok  = 1'b0;
    frame_done_err = 1'b0;
  endtask : end_frame

  task automatic read_frame(input logic [5:0] addr, input logic bad,
                            output logic [15:0] data, output logic valid);
    @(negedge sys_clk);
    reg_rd_strobe = 1'b1;
    reg_addr      = addr;
    @(negedge sys_clk);
    reg_rd_strobe = 1'b0;
    valid         = rd_valid_q;
    data          = rd_data_q;
    reg_addr      = ~addr;
    end_frame(bad);
  endtask : read_frame

  task automatic write_frame(input logic [5:0] addr, input logic [15:0] data);
    @(negedge sys_clk);
    reg_wr_strobe = 1'b1;
    reg_addr      = addr;
    reg_wdata     = data;
    @(negedge sys_clk);
    reg_wr_strobe = 1'b0;
    reg_addr      = ~addr;
    reg_wdata     = ~data;
    end_frame(1'b0);
  endtask : write_frame
endmodule : gfs_host_model

// *** verif/test_global_fault_status_reg.sv ***
module test_global_fault_status_reg;
  timeunit 1ns;
  timeprecision 1ps;

  logic        sys_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [2:0]  pins    = 3'h0;
  logic        fb_pin  = 1'b0;
  logic        fhd     = 1'b0;
  logic        to_en   = 1'b0;
  logic        to_exp  = 1'b0;
  logic        spi_err = 1'b0;
  logic        self_lp = 1'b0;
  logic        host_lp = 1'b0;
  logic        refused = 1'b0;
  logic        rd_s, wr_s, ok, bad, rv, vld, fb_q, diag_q, glob_q;
  logic [5:0]  addr;
  logic [15:0] wdata, rdata, got, ev_exp;
  int          errors      = 0;
  int          comparisons = 0;
  int          cycles      = 0;

  always #12.5 sys_clk = ~sys_clk;

  gfs_global_fault u_gfs_global_fault (
    .sys_clk(sys_clk), .reset_n(reset_n), .fallback_request_pin(fb_pin),
    .logic_supply_low_pin(pins[2]), .battery_warn_pin(pins[1]),
    .battery_lockout_pin(pins[0]), .fault_hold_disable(fhd),
    .host_timeout_enable(to_en), .host_timeout_expired(to_exp),
    .spi_error_cond(spi_err), .self_lowpower_mode(self_lp),
    .host_lowpower_mode(host_lp), .lowpower_entry_refused(refused),
    .reg_rd_strobe(rd_s), .reg_wr_strobe(wr_s), .reg_addr(addr), .reg_wdata(wdata),
    .frame_done_ok(ok), .frame_done_err(bad), .rd_data_q(rdata), .rd_valid_q(rv),
    .fallback_state_q(fb_q), .diag_disable_q(diag_q), .global_event_flag_q(glob_q)
  );

  gfs_host_model u_gfs_host_model (
    .sys_clk(sys_clk), .rd_valid_q(rv), .rd_data_q(rdata), .reg_rd_strobe(rd_s),
    .reg_wr_strobe(wr_s), .reg_addr(addr), .reg_wdata(wdata), .frame_done_ok(ok),
    .frame_done_err(bad)
  );

  task automatic final_report();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
    begin
      $display("All checks passed");
    end
    else
    begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report

  task automatic check16(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e)
    begin
      errors++;
      $display("wrong value at %0t: register read %h, expected %h", $time, g, e);
    end
  endtask : check16

  task automatic check1(input logic g, input logic e);
    comparisons++;
    if (g !== e)
    begin
      errors++;
      $display("wrong value at %0t: flag output %b, expected %b", $time, g, e);
    end
  endtask : check1

  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : tick

  task automatic rd(input logic [15:0] e, input logic b);
    u_gfs_host_model.read_frame(6'h04, b, got, vld);
    check1(vld, 1'b1);
    check16(got, e);
  endtask : rd

  // Drives one same-clock event source selected by k.
  task automatic drive_ev(input int k, input logic v);
    case (k)
      0: spi_err = v;
      1: to_exp = v;
      2: self_lp = v;
      default: host_lp = v;
    endcase
  endtask : drive_ev

  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      errors++;
      final_report();
    end
  end

  initial
  begin
    tick(3);
    reset_n = 1'b1;
    check1(glob_q, 1'b1);
    u_gfs_host_model.read_frame(6'h05, 1'b0, got, vld);
    check16(got, 16'h0000);
    rd(16'h0147, 1'b1);
    rd(16'h0147, 1'b0);
    rd(16'h0000, 1'b0);
    check1(glob_q, 1'b0);
    for (int i = 0; i < 3; i++)
    begin
      pins[i] = 1'b1;
      tick(4);
      check1(diag_q, i == 1);
      rd(16'h0100 | (16'h0001 << i), 1'b0);
      pins = 3'h0;
      tick(4);
      rd(16'h0100 | (16'h0001 << i), 1'b0);
      rd(16'h0000, 1'b0);
    end
    to_en = 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      ev_exp = (k == 0) ? 16'h0110 : (k == 1) ? 16'h0108 : 16'h0120;
      drive_ev(k, 1'b1);
      tick(2);
      check1(glob_q, 1'b1);
      rd(ev_exp, 1'b0);
      rd(ev_exp, 1'b0);
      drive_ev(k, 1'b0);
      tick(1);
      rd(ev_exp, 1'b0);
      rd(16'h0000, 1'b0);
    end
    to_en = 1'b0;
    to_exp = 1'b1;
    tick(2);
    rd(16'h0000, 1'b0);
    to_exp = 1'b0;
    refused = 1'b1;
    tick(1);
    refused = 1'b0;
    rd(16'h0120, 1'b0);
    rd(16'h0000, 1'b0);
    spi_err = 1'b1;
    tick(1);
    spi_err = 1'b0;
    rd(16'h0110, 1'b1);
    rd(16'h0110, 1'b0);
    rd(16'h0000, 1'b0);
    for (int m = 0; m < 2; m++)
    begin
      fhd = m[0];
      fb_pin = 1'b1;
      tick(4);
      check1(fb_q, 1'b1);
      u_gfs_host_model.write_frame(6'h04, 16'h0080);
      check1(fb_q, 1'b1);
      rd(16'h0180, 1'b0);
      fb_pin = 1'b0;
      tick(4);
      u_gfs_host_model.write_frame(6'h04, 16'h0080);
      check1(fb_q, 1'b0);
      check1(glob_q, !m[0]);
      rd(m[0] ? 16'h0000 : 16'h0100, 1'b0);
      rd(16'h0000, 1'b0);
    end
    final_report();
  end
endmodule : test_global_fault_status_reg
